// >>> rtl/dma_ctl_defines.svh
// What this block does
// - a masked channel's request is ignored and never serviced.
// - system reset sets every channel mask bit to one, master clear those of its group.
// - clear-all-masks command clears every mask bit of the addressed group.
// - single-mask write: bit 2 is the value, bits 1:0 the channel, 7:3 zero.
// - all-masks write: bits 3:0 load channel masks 3..0, bits 7:4 zero.
// - each channel keeps a write-only mode, stored internally decoded.
// - mode bit 5 picks address increment (0) or decrement (1).
// - mode bit 4 enables auto-initialize after terminal count.
// - mode bits 3:2 pick verify, write or read; 11 is reserved.
// - mode bits 1:0 pick the channel in the group; bits 7:6 zero.
// - two readable status bytes, one per group of four channels.
// - status bits 3:0 latch terminal count per channel until cleared.
// - reset or a status read clears the terminal count bits 3:0.
// - status bits 7:4 show pending requests of channels three to zero.
// - writing the status address loads the group's command register.
// - command bit 7 sets acknowledge polarity, bit 6 request polarity.
// - command bit 5 picks late or extended write, bit 4 priority scheme.
// - command bit 3 compressed timing, bit 2 disables controller, bit 0 zero.
// - 16-bit address and count registers move as successive bytes.
// - terminal count is when the count wraps 0000 to FFFF, with a pulse.
`ifndef DMA_CTL_DEFINES_SVH
`define DMA_CTL_DEFINES_SVH

// group 0 sits on byte addresses 0x00..0x0F, group 1 on even words 0xC0..0xDE
`define DMA_G0_BASE       16'h0000
`define DMA_G0_MASK       16'hFFF0
`define DMA_G1_BASE       16'h00C0
`define DMA_G1_MASK       16'hFFE0

// register index within a group
`define DMA_IDX_WORD_LAST 4'h7
`define DMA_IDX_STATUS    4'h8
`define DMA_IDX_SMASK     4'hA
`define DMA_IDX_MODE      4'hB
`define DMA_IDX_CLR_BP    4'hC
`define DMA_IDX_MCLR      4'hD
`define DMA_IDX_CLR_MASK  4'hE
`define DMA_IDX_ALL_MASK  4'hF

// field positions
`define DMA_SMASK_VAL     2
`define DMA_MODE_DEC      5
`define DMA_MODE_AUTO     4
`define DMA_MODE_XFER_LO  2
`define DMA_CMD_ACK_HI    7
`define DMA_CMD_REQ_LO    6
`define DMA_CMD_EXT_WR    5
`define DMA_CMD_ROTATE    4
`define DMA_CMD_COMPRESS  3
`define DMA_CMD_DISABLE   2

// reset values
`define DMA_MASK_RST      4'hF
`define DMA_CMD_RST       8'h00
`define DMA_TC_RST        4'h0
`define DMA_MODE_RST      8'h00

`endif

// >>> rtl/dma_ctl_pkg.sv
package dma_ctl_pkg;

    typedef enum logic [1:0]
    {
        XFER_VERIFY   = 2'h0,
        XFER_WRITE    = 2'h1,
        XFER_READ     = 2'h2,
        XFER_RESERVED = 2'h3
    } xfer_kind_type;

    typedef logic [3:0] group_vec_type;

endpackage

// >>> rtl/dma_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module dma_sync2 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/dma_chan_mode.sv
`timescale 1ns/100ps
`default_nettype none
`include "dma_ctl_defines.svh"

module dma_chan_mode
    import dma_ctl_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      rstn_in,
    input  wire logic                      load_in,
    input  wire logic [7:0]                mode_in,
    output var  logic                      decrement_out,
    output var  logic                      auto_init_out,
    output var  dma_ctl_pkg::xfer_kind_type xfer_out
);

    import dma_ctl_pkg::*;

    // a literal cannot be bit-selected, so the reset byte gets a name first
    localparam logic [7:0] MODE_RST = `DMA_MODE_RST;

    // kept decoded, never read back
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            decrement_out <= MODE_RST[`DMA_MODE_DEC];
            auto_init_out <= MODE_RST[`DMA_MODE_AUTO];
            xfer_out      <= XFER_VERIFY;
        end
        else if (load_in)
        begin
            decrement_out <= mode_in[`DMA_MODE_DEC];
            auto_init_out <= mode_in[`DMA_MODE_AUTO];
            xfer_out      <= xfer_kind_type'(mode_in[`DMA_MODE_XFER_LO +: 2]);
        end
    end

endmodule

`default_nettype wire

// >>> rtl/dma_ctl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dma_ctl_defines.svh"

module dma_ctl_top
    import dma_ctl_pkg::*;
(
    input  wire logic                       clk_in,
    input  wire logic                       rstn_in,
    input  wire logic [15:0]                io_addr_in,
    input  wire logic [7:0]                 io_wdata_in,
    input  wire logic                       io_wr_in,
    input  wire logic                       io_rd_in,
    output var  logic [7:0]                 io_rdata_out,
    output var  logic                       io_rdata_valid_out,
    input  wire logic [7:0]                 dma_request_line_in,
    input  wire logic [7:0]                 tc_pulse_in,
    output var  logic [7:0]                 channel_request_out,
    output var  logic [7:0]                 mask_out,
    output var  logic [1:0]                 byte_pointer_out,
    output var  logic [7:0]                 addr_decrement_out,
    output var  logic [7:0]                 auto_init_out,
    output var  dma_ctl_pkg::xfer_kind_type xfer_type_out [8],
    output var  logic [1:0]                 ack_active_high_out,
    output var  logic [1:0]                 req_active_low_out,
    output var  logic [1:0]                 extended_write_out,
    output var  logic [1:0]                 rotating_priority_out,
    output var  logic [1:0]                 compressed_timing_out,
    output var  logic [1:0]                 controller_disable_out
);

    import dma_ctl_pkg::*;

    logic [1:0] grp_wr;
    logic [1:0] grp_rd;
    logic [3:0] grp_idx [2];
    logic [7:0] req_sync;
    logic [7:0] req_active;
    logic [7:0] mask_r;
    logic [7:0] tc_r;
    logic [7:0] cmd_r [2];
    logic [1:0] bp_r;
    logic [7:0] mode_ld;
    logic [1:0] mclr;
    logic [1:0] stat_rd;

    // request pins come from outside the clock domain
    dma_sync2 #(
        .WIDTH (8)
    ) u_req_sync (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (dma_request_line_in),
        .sync_out (req_sync)
    );

    // address decode: one byte-wide I/O access per strobe
    always_comb
    begin
        grp_wr     = 2'b00;
        grp_rd     = 2'b00;
        grp_idx[0] = io_addr_in[3:0];
        grp_idx[1] = io_addr_in[4:1];
        if ((io_addr_in & `DMA_G0_MASK) == `DMA_G0_BASE)
        begin
            grp_wr[0] = io_wr_in;
            grp_rd[0] = io_rd_in;
        end
        if (((io_addr_in & `DMA_G1_MASK) == `DMA_G1_BASE) && !io_addr_in[0])
        begin
            grp_wr[1] = io_wr_in;
            grp_rd[1] = io_rd_in;
        end
    end

    always_comb
    begin
        for (int g = 0; g < 2; g++)
        begin
            mclr[g]    = grp_wr[g] && (grp_idx[g] == `DMA_IDX_MCLR);
            stat_rd[g] = grp_rd[g] && (grp_idx[g] == `DMA_IDX_STATUS);
        end
    end

    // request polarity follows the group's command byte
    always_comb
    begin
        for (int ch = 0; ch < 8; ch++)
        begin
            req_active[ch] = req_sync[ch] ^ cmd_r[ch / 4][`DMA_CMD_REQ_LO];
        end
    end

    // mask bits
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mask_r <= {`DMA_MASK_RST, `DMA_MASK_RST};
        end
        else
        begin
            for (int g = 0; g < 2; g++)
            begin
                if (mclr[g])
                begin
                    mask_r[g*4 +: 4] <= `DMA_MASK_RST;
                end
                else if (grp_wr[g])
                begin
                    unique case (grp_idx[g])
                        `DMA_IDX_SMASK:
                        begin
                            // upper bits are zero by contract and not looked at
                            mask_r[g*4 + io_wdata_in[1:0]] <=
                                io_wdata_in[`DMA_SMASK_VAL];
                        end
                        `DMA_IDX_CLR_MASK:
                        begin
                            mask_r[g*4 +: 4] <= 4'h0;
                        end
                        `DMA_IDX_ALL_MASK:
                        begin
                            mask_r[g*4 +: 4] <= io_wdata_in[3:0];
                        end
                        default:
                        begin
                            mask_r[g*4 +: 4] <= mask_r[g*4 +: 4];
                        end
                    endcase
                end
            end
        end
    end

    // command registers share the status address on writes
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cmd_r[0] <= `DMA_CMD_RST;
            cmd_r[1] <= `DMA_CMD_RST;
        end
        else
        begin
            for (int g = 0; g < 2; g++)
            begin
                if (mclr[g])
                begin
                    cmd_r[g] <= `DMA_CMD_RST;
                end
                else if (grp_wr[g] && (grp_idx[g] == `DMA_IDX_STATUS))
                begin
                    cmd_r[g] <= io_wdata_in;
                end
            end
        end
    end

    // terminal count flags: a pulse in the clearing cycle wins over the clear
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tc_r <= {`DMA_TC_RST, `DMA_TC_RST};
        end
        else
        begin
            for (int ch = 0; ch < 8; ch++)
            begin
                if (tc_pulse_in[ch])
                begin
                    tc_r[ch] <= 1'b1;
                end
                else if (stat_rd[ch / 4] || mclr[ch / 4])
                begin
                    tc_r[ch] <= 1'b0;
                end
            end
        end
    end

    // byte pointer per group, shared by its address and count registers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bp_r <= 2'b00;
        end
        else
        begin
            for (int g = 0; g < 2; g++)
            begin
                if ((grp_wr[g] && (grp_idx[g] == `DMA_IDX_CLR_BP)) || mclr[g])
                begin
                    bp_r[g] <= 1'b0;
                end
                else if ((grp_wr[g] || grp_rd[g]) && (grp_idx[g] <= `DMA_IDX_WORD_LAST))
                begin
                    bp_r[g] <= ~bp_r[g];
                end
            end
        end
    end

    // read data: status byte or zero for anything else in this block
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            io_rdata_out       <= 8'h00;
            io_rdata_valid_out <= 1'b0;
        end
        else
        begin
            io_rdata_valid_out <= io_rd_in;
            if (stat_rd[0])
            begin
                io_rdata_out <= {req_active[3:0], tc_r[3:0]};
            end
            else if (stat_rd[1])
            begin
                io_rdata_out <= {req_active[7:4], tc_r[7:4]};
            end
            else if (io_rd_in)
            begin
                io_rdata_out <= 8'h00;
            end
        end
    end

    // service requests: masked or disabled channels are dropped
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            channel_request_out <= 8'h00;
        end
        else
        begin
            for (int ch = 0; ch < 8; ch++)
            begin
                channel_request_out[ch] <= req_active[ch] && !mask_r[ch] &&
                    !cmd_r[ch / 4][`DMA_CMD_DISABLE];
            end
        end
    end

    always_comb
    begin
        for (int ch = 0; ch < 8; ch++)
        begin
            mode_ld[ch] = grp_wr[ch / 4] && (grp_idx[ch / 4] == `DMA_IDX_MODE) &&
                (io_wdata_in[1:0] == 2'(ch % 4));
        end
    end

    for (genvar ch = 0; ch < 8; ch++)
    begin : g_mode
        dma_chan_mode u_mode (
            .clk_in        (clk_in),
            .rstn_in       (rstn_in),
            .load_in       (mode_ld[ch]),
            .mode_in       (io_wdata_in),
            .decrement_out (addr_decrement_out[ch]),
            .auto_init_out (auto_init_out[ch]),
            .xfer_out      (xfer_type_out[ch])
        );
    end

    assign mask_out         = mask_r;
    assign byte_pointer_out = bp_r;

    always_comb
    begin
        for (int g = 0; g < 2; g++)
        begin
            ack_active_high_out[g]    = cmd_r[g][`DMA_CMD_ACK_HI];
            req_active_low_out[g]     = cmd_r[g][`DMA_CMD_REQ_LO];
            extended_write_out[g]     = cmd_r[g][`DMA_CMD_EXT_WR];
            rotating_priority_out[g]  = cmd_r[g][`DMA_CMD_ROTATE];
            compressed_timing_out[g]  = cmd_r[g][`DMA_CMD_COMPRESS];
            controller_disable_out[g] = cmd_r[g][`DMA_CMD_DISABLE];
        end
    end

endmodule

`default_nettype wire

// >>> verification/dma_ctl_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dma_ctl_checker (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [7:0]  io_wdata_in,
    input wire logic        io_wr_in,
    input wire logic        io_rd_in,
    input wire logic [7:0]  io_rdata_out,
    input wire logic        io_rdata_valid_out,
    input wire logic [7:0]  tc_pulse_in,
    input wire logic [7:0]  channel_request_out,
    input wire logic [7:0]  mask_out,
    input wire logic [1:0]  byte_pointer_out,
    input wire logic [7:0]  addr_decrement_out,
    input wire logic [7:0]  auto_init_out,
    input wire logic [1:0]  ack_active_high_out,
    input wire logic [1:0]  controller_disable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    function automatic logic wa(input logic [15:0] a);
        return io_wr_in && io_addr_in == a;
    endfunction
    sequence s_stat_rd;
        io_rd_in && io_addr_in == 16'h0008 && tc_pulse_in[3:0] == 4'h0;
    endsequence
    sequence s_quiet_gap;
        (tc_pulse_in[3:0] == 4'h0) [*2];
    endsequence
    property p_rd_valid; io_rd_in |=> io_rdata_valid_out; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read answer late");
    property p_smask;
        wa(16'h000a) |=> mask_out[$past(io_wdata_in[1:0])] == $past(io_wdata_in[2]);
    endproperty
    a_smask: assert property (p_smask) else $error("single mask wrong");
    property p_amask; wa(16'h000f) |=> mask_out[3:0] == $past(io_wdata_in[3:0]); endproperty
    a_amask: assert property (p_amask) else $error("all mask wrong");
    property p_cmask; wa(16'h000e) |=> mask_out[3:0] == 4'h0; endproperty
    a_cmask: assert property (p_cmask) else $error("mask clear missed");
    property p_mclr; wa(16'h00da) |=> mask_out[7:4] == 4'hf; endproperty
    a_mclr: assert property (p_mclr) else $error("master clear missed");
    property p_masked; ($past(mask_out) & channel_request_out) == 8'h00; endproperty
    a_masked: assert property (p_masked) else $error("masked request served");
    property p_mode;
        wa(16'h000b) |=> addr_decrement_out[$past(io_wdata_in[1:0])] == $past(io_wdata_in[5])
            && auto_init_out[$past(io_wdata_in[1:0])] == $past(io_wdata_in[4]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not loaded");
    property p_cmd;
        wa(16'h0008) |=> ack_active_high_out[0] == $past(io_wdata_in[7])
            && controller_disable_out[0] == $past(io_wdata_in[2]);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not loaded");
    property p_tc_clear; s_stat_rd ##1 s_quiet_gap ##0 s_stat_rd |=> io_rdata_out[3:0] == 4'h0;
    endproperty
    a_tc_clear: assert property (p_tc_clear) else $error("status not cleared");
    property p_bp_clr; wa(16'h000c) |=> byte_pointer_out[0] == 1'b0; endproperty
    a_bp_clr: assert property (p_bp_clr) else $error("byte pointer kept");
endmodule
bind dma_ctl_top dma_ctl_checker i_dma_ctl_checker (.clk_in, .rstn_in, .io_addr_in,
    .io_wdata_in, .io_wr_in, .io_rd_in, .io_rdata_out, .io_rdata_valid_out, .tc_pulse_in,
    .channel_request_out, .mask_out, .byte_pointer_out, .addr_decrement_out, .auto_init_out,
    .ack_active_high_out, .controller_disable_out);
`default_nettype wire

// >>> verification/dma_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module dma_dev_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] want_in,
    input  wire logic [1:0] active_low_in,
    output var  logic [7:0] pins_out
);
    // devices move their pins just after an edge, never in step with the sampler
    always_ff @(posedge clk_in)
        pins_out <= #1 want_in ^ {{4{active_low_in[1]}}, {4{active_low_in[0]}}};
endmodule
`default_nettype wire

// >>> verification/tb_dma_ctl_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dma_ctl_top;
    import dma_ctl_pkg::*;
    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] m;} row_type;
    logic          clk_in = 0, rstn_in = 0, io_wr_in = 0, io_rd_in = 0, v, io_rdata_valid_out;
    logic [15:0]   io_addr_in = 0;
    logic [7:0]    io_wdata_in = 0, tc_pulse_in = 0, want = 0, q, pins, io_rdata_out;
    logic [7:0]    channel_request_out, mask_out, addr_decrement_out, auto_init_out;
    logic [1:0]    byte_pointer_out, ack, req, ext, rot, cmp, dis;
    xfer_kind_type xfer [8];
    int            num_errors = 0, tests_run = 0;
    row_type       rows [9] = '{'{16'h000e, 8'h00, 8'hf0}, '{16'h000a, 8'h06, 8'hf4},
        '{16'h000a, 8'h02, 8'hf0}, '{16'h000f, 8'h0a, 8'hfa}, '{16'h00dc, 8'h00, 8'h0a},
        '{16'h00d4, 8'h05, 8'h2a}, '{16'h00de, 8'h0c, 8'hca}, '{16'h000d, 8'h00, 8'hcf},
        '{16'h00da, 8'h00, 8'hff}};
    dma_ctl_top i_dma_ctl_top (.clk_in, .rstn_in, .io_addr_in, .io_wdata_in, .io_wr_in,
        .io_rd_in, .io_rdata_out, .io_rdata_valid_out, .dma_request_line_in(pins), .tc_pulse_in,
        .channel_request_out, .mask_out, .byte_pointer_out, .addr_decrement_out, .auto_init_out,
        .xfer_type_out(xfer), .ack_active_high_out(ack), .req_active_low_out(req),
        .extended_write_out(ext), .rotating_priority_out(rot), .compressed_timing_out(cmp),
        .controller_disable_out(dis));
    dma_dev_model i_dma_dev_model (.clk_in, .want_in(want), .active_low_in(req), .pins_out(pins));
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end
    task automatic final_report;
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        io_addr_in = a;
        io_wdata_in = d;
        io_wr_in = 1;
        @(negedge clk_in);
        io_wr_in = 0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge clk_in);
        io_addr_in = a;
        io_rd_in = 1;
        @(negedge clk_in);
        io_rd_in = 0;
        q = io_rdata_out;
        v = io_rdata_valid_out;
    endtask
    initial
    begin
        #20000;
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (12) @(negedge clk_in);
        rstn_in = 1;
        chk(mask_out, 8'hff);
        chk({byte_pointer_out, ack, req, dis}, 8'h00);
        $display("test reset done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk(mask_out, rows[i].m);
        end
        $display("test masks done");
        for (int k = 0; k < 4; k++)
        begin
            logic [1:0] x;
            // the reserved transfer code is kept out of traffic
            x = k[1:0] & {~k[0], 1'b1};
            wr(16'h000b, {2'b00, k[0], k[1], x, k[1:0]});
            wr(16'h00d6, {2'b00, k[0], k[1], x, k[1:0]});
            chk({addr_decrement_out[k], auto_init_out[k], xfer[k], addr_decrement_out[k+4],
                auto_init_out[k+4], xfer[k+4]}, {2{k[0], k[1], x}});
        end
        $display("test mode done");
        wr(16'h0008, 8'hfc);
        chk({ack, req, ext, rot}, 8'h55);
        chk({cmp, dis, 4'h0}, 8'h50);
        wr(16'h0008, 8'h00);
        rd(16'h0004);
        chk({6'h00, byte_pointer_out}, 8'h01);
        wr(16'h00c8, 8'h12);
        chk({6'h00, byte_pointer_out}, 8'h03);
        wr(16'h000c, 8'h00);
        chk({6'h00, byte_pointer_out}, 8'h02);
        rd(16'h0050);
        chk({q[6:0], v}, 8'h01);
        $display("test command and pointer done");
        wr(16'h000a, 8'h01);
        want = 8'h02;
        repeat (5) @(negedge clk_in);
        chk(channel_request_out, 8'h02);
        rd(16'h0008);
        chk(q, 8'h20);
        wr(16'h000a, 8'h05);
        @(negedge clk_in);
        chk(channel_request_out, 8'h00);
        rd(16'h0008);
        chk(q, 8'h20);
        wr(16'h0008, 8'h40);
        repeat (5) @(negedge clk_in);
        rd(16'h0008);
        chk(q, 8'h20);
        wr(16'h0008, 8'h00);
        repeat (5) @(negedge clk_in);
        tc_pulse_in = 8'h04;
        @(negedge clk_in);
        tc_pulse_in = 8'h00;
        rd(16'h0008);
        chk(q, 8'h24);
        rd(16'h0008);
        chk(q, 8'h20);
        $display("test request and status done");
        wr(16'h000a, 8'h06);
        wr(16'h000c, 8'h00);
        wr(16'h0004, 8'h34);
        wr(16'h0004, 8'h12);
        wr(16'h0081, 8'h00);
        wr(16'h000c, 8'h00);
        wr(16'h0005, 8'hff);
        wr(16'h0005, 8'h00);
        wr(16'h000b, 8'h16);
        wr(16'h000a, 8'h02);
        chk({mask_out[2], byte_pointer_out[0], addr_decrement_out[2], auto_init_out[2],
            xfer[2], 2'b00}, 8'h14);
        $display("test setup sequence done");
        tc_pulse_in = 8'h01;
        @(negedge clk_in);
        tc_pulse_in = 8'h00;
        rstn_in = 0;
        repeat (3) @(negedge clk_in);
        rstn_in = 1;
        chk(mask_out, 8'hff);
        chk({byte_pointer_out, ack, req, dis}, 8'h00);
        rd(16'h0008);
        chk({4'h0, q[3:0]}, 8'h00);
        $display("test reset in mid run done");
        final_report();
    end
endmodule
`default_nettype wire
